// *** sim/nfc_flash_model.sv ***
// nfc_flash_model: behavioural flash device on the far side of nfc_host
// assumes pins registered by the host; i/o resolved by the bench
`timescale 1ns/1ns
`default_nettype none
module nfc_flash_model (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    // strobes and bus
    input  wire logic       ce_n_in,
    input  wire logic       cle_in,
    input  wire logic       ale_in,
    input  wire logic       we_n_in,
    input  wire logic       read_strobe_n_in,
    input  wire logic [7:0] io_in,
    output logic      [7:0] io_out,
    output logic            rb_out,
    // last latched byte
    output logic      [7:0] last_byte_out,
    output logic            last_cle_out,
    output logic            last_ale_out
);
    logic       we_q_r;
    logic       re_q_r;
    logic [7:0] col_r;
    logic [4:0] busy_r;
    // column byte while selected and read strobe low, inverse otherwise
    assign io_out = (read_strobe_n_in || ce_n_in) ? ~col_r : col_r;
    assign rb_out = (busy_r == 5'h00);
    // latch on write strobe rise, count busy, step column
    always @(posedge clock_in) begin
        we_q_r <= we_n_in;
        re_q_r <= read_strobe_n_in;
        if (busy_r != 5'h00)
            busy_r <= busy_r - 5'h01;
        if (!reset_n_in) begin
            col_r <= 8'h00;
            busy_r <= 5'h00;
        end else if (we_n_in && !we_q_r && !ce_n_in) begin
            last_byte_out <= io_in;
            last_cle_out <= cle_in;
            last_ale_out <= ale_in;
            if (cle_in && io_in inside {8'h10, 8'h11, 8'h15, 8'h30, 8'h31,
                8'h33, 8'h35, 8'h3A, 8'h3F, 8'hD0, 8'hFF})
                busy_r <= 5'h0C;
        end else if (read_strobe_n_in && !re_q_r)
            col_r <= col_r + 8'h01;
    end
endmodule
`default_nettype wire

// *** sim/nfc_host_chk_chk.sv ***
// nfc_host_chk: pin and request checks on the nfc_host ports
// assumes bound into nfc_host
`timescale 1ns/1ns
`default_nettype none
module nfc_host_chk #(
    parameter int STROBE_CYC_P = nfc_pkg::STROBE_CYC
) (
    // clock, reset and request side
    input wire logic       clock_in,
    input wire logic       reset_n_in,
    input wire logic       req_valid_in,
    input wire logic       req_ready_out,
    input wire logic [1:0] req_kind_in,
    input wire logic [7:0] req_byte_in,
    input wire logic       req_err_out,
    input wire logic       busy_out,
    // flash pins
    input wire logic       ce_n_out,
    input wire logic       cle_out,
    input wire logic       ale_out,
    input wire logic       we_n_out,
    input wire logic       read_strobe_n_out,
    input wire logic [7:0] io_out,
    input wire logic       io_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    wire logic  take = req_valid_in && req_ready_out;
    logic [3:0] low_cnt_r;
    // cycles spent with the write strobe low
    always_ff @(posedge clock_in) begin
        if (!reset_n_in || we_n_out)
            low_cnt_r <= 4'h0;
        else
            low_cnt_r <= low_cnt_r + 4'h1;
    end
    property p_we_ce; !we_n_out |-> !ce_n_out; endproperty
    a_we_ce: assert property (p_we_ce) else $error("strobe unselected");
    property p_strobe; $rose(we_n_out) |-> low_cnt_r == 4'(STROBE_CYC_P);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe length");
    property p_cle_ale; !(cle_out && ale_out); endproperty
    a_cle_ale: assert property (p_cle_ale) else $error("both latches");
    property p_cmd; take && req_kind_in == nfc_pkg::KIND_CMD |=> req_err_out
        || (cle_out && !ale_out && !we_n_out && io_oe_out
        && io_out == $past(req_byte_in)); endproperty
    a_cmd: assert property (p_cmd) else $error("command cycle");
    property p_addr; take && req_kind_in == nfc_pkg::KIND_ADDR |=> req_err_out
        || (ale_out && !cle_out && io_out == $past(req_byte_in)); endproperty
    a_addr: assert property (p_addr) else $error("address cycle");
    property p_rd; take && req_kind_in == nfc_pkg::KIND_RDATA |=>
        !read_strobe_n_out && !io_oe_out && !ce_n_out; endproperty
    a_rd: assert property (p_rd) else $error("read cycle");
    property p_err; req_err_out |-> we_n_out && read_strobe_n_out; endproperty
    a_err: assert property (p_err) else $error("refusal moved pins");
    property p_busy; busy_out |-> !req_ready_out; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
endmodule
bind nfc_host nfc_host_chk #(.STROBE_CYC_P(STROBE_CYC_P)) u_nfc_host_chk (
    .clock_in, .reset_n_in, .req_valid_in, .req_ready_out, .req_kind_in,
    .req_byte_in, .req_err_out, .busy_out, .ce_n_out, .cle_out, .ale_out,
    .we_n_out, .read_strobe_n_out, .io_out, .io_oe_out);
`default_nettype wire

// *** sim/tb.sv ***
// tb: self-checking bench for nfc_host against a flash model
// assumes default timing parameters and a 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [1:0] KC = nfc_pkg::KIND_CMD;
    localparam logic [1:0] KR = nfc_pkg::KIND_RDATA;
    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        req_valid_in = 1'b0;
    logic [1:0]  req_kind_in = 2'h0;
    logic [7:0]  req_byte_in = 8'h00;
    logic        rd_ready_in = 1'b0;
    logic        rd_rand = 1'b0;
    wire logic   req_ready_out, req_err_out, rd_valid_out, busy_out;
    wire logic   ce_n_out, cle_out, ale_out, we_n_out, wp_n_out, io_oe_out;
    wire logic   read_strobe_n_out, ready_busy_in, last_cle, last_ale;
    wire logic [7:0] rd_data_out, io_out, io_in, fl_io, last_byte;
    int          error_cnt = 0;
    int          compares = 0;
    logic [31:0] rng = 32'd43758;
    logic [31:0] rs = 32'd43758;
    logic [7:0]  rd_n = 8'h00;
    logic [7:0]  exp_q[$];
    logic [7:0]  one[7] = '{8'h70, 8'hF1, 8'hF2, 8'h90, 8'hEC, 8'hEF, 8'hFF};
    logic [7:0]  tp[5] = '{8'hD0, 8'h30, 8'h35, 8'h3A, 8'h33};
    always #10 clock_in = ~clock_in;
    assign io_in = io_oe_out ? io_out : fl_io;
    nfc_host u_nfc_host (.clock_in, .reset_n_in, .req_valid_in,
        .req_ready_out, .req_kind_in, .req_byte_in, .req_err_out,
        .rd_valid_out, .rd_ready_in, .rd_data_out, .busy_out, .ce_n_out,
        .cle_out, .ale_out, .we_n_out, .read_strobe_n_out, .wp_n_out,
        .io_in, .io_out, .io_oe_out, .ready_busy_in);
    nfc_flash_model u_nfc_flash_model (.clock_in, .reset_n_in,
        .ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out),
        .we_n_in(we_n_out), .read_strobe_n_in(read_strobe_n_out),
        .io_in(io_in), .io_out(fl_io), .rb_out(ready_busy_in),
        .last_byte_out(last_byte), .last_cle_out(last_cle),
        .last_ale_out(last_ale));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // bounded wait at falling edges for the request port
    task automatic wait_ready;
        for (int n = 0; req_ready_out !== 1'b1; n++) begin
            if (n > 500) begin
                error_cnt++;
                give_verdict;
            end
            @(negedge clock_in);
        end
    endtask
    // one request, its refusal flag and the byte the device latched
    task automatic step(input logic [1:0] k, input logic e,
                        input logic [7:0] b);
        req_kind_in = k;
        req_byte_in = b;
        req_valid_in = 1'b1;
        wait_ready;
        if (k == KR) begin
            exp_q.push_back(rd_n);
            rd_n++;
        end
        @(negedge clock_in);
        req_valid_in = 1'b0;
        check("refusal", {7'h0, req_err_out}, {7'h0, e});
        if (!e && k != KR) begin
            wait_ready;
            check("latched byte", last_byte, b);
            check("latch path", {6'h0, last_cle, last_ale},
                  {6'h0, k == KC, k == nfc_pkg::KIND_ADDR});
        end else
            @(negedge clock_in);
    endtask
    task automatic bytes(input logic [1:0] k, input int n);
        repeat (n) begin
            rng = xs(rng);
            step(k, 1'b0, rng[7:0]);
        end
    endtask
    task automatic op(input logic [7:0] s, input int na, input int nd,
                      input logic [7:0] c, input logic e);
        step(KC, 1'b0, s);
        bytes(nfc_pkg::KIND_ADDR, na);
        bytes(nfc_pkg::KIND_WDATA, nd);
        step(KC, e, c);
    endtask
    // read consumer with random stalls, compares oldest expected byte
    always @(negedge clock_in) begin
        rs = xs(rs);
        rd_ready_in = rd_rand & rs[0];
        if (rd_valid_out === 1'b1 && rd_ready_in) begin
            if (exp_q.size() == 0)
                check("extra byte", 8'(exp_q.size()), 8'h01);
            else
                check("read byte", rd_data_out, exp_q.pop_front());
        end
    end
    initial begin
        repeat (16) @(posedge clock_in);
        @(negedge clock_in);
        reset_n_in = 1'b1;
        step(KC, 1'b1, 8'h05);
        step(KC, 1'b1, 8'h30);
        step(KC, 1'b1, 8'h07);
        foreach (one[i]) step(KC, 1'b0, one[i]);
        op(8'h00, 5, 0, 8'h30, 1'b0);
        bytes(KR, 2);
        req_valid_in = 1'b1;
        repeat (6) @(negedge clock_in);
        check("full stall", {7'h0, req_ready_out}, 8'h00);
        rd_rand = 1'b1;
        bytes(KR, 3);
        step(KC, 1'b0, 8'h31);
        step(KC, 1'b0, 8'h3F);
        op(8'h00, 5, 0, 8'h35, 1'b0);
        op(8'h00, 5, 0, 8'h3A, 1'b0);
        op(8'h80, 5, 2, 8'h10, 1'b0);
        op(8'h80, 5, 2, 8'h15, 1'b0);
        op(8'h85, 5, 0, 8'h10, 1'b0);
        op(8'h8C, 5, 0, 8'h15, 1'b0);
        op(8'h60, 3, 0, 8'hD0, 1'b0);
        op(8'h60, 5, 0, 8'hD0, 1'b1);
        op(8'h80, 5, 1, 8'h11, 1'b0);
        step(KC, 1'b1, 8'h90);
        op(8'h81, 5, 1, 8'h10, 1'b0);
        op(8'h8C, 5, 0, 8'h11, 1'b0);
        op(8'h81, 5, 0, 8'h15, 1'b0);
        op(8'h80, 5, 0, 8'h90, 1'b0);
        step(KC, 1'b1, 8'h10);
        foreach (tp[i]) begin
            op(8'h60, 3, 0, 8'h60, 1'b0);
            bytes(nfc_pkg::KIND_ADDR, 3);
            step(KC, 1'b0, tp[i]);
        end
        foreach (tp[i]) op(8'h00, 0, 3, tp[i], 1'b1);
        op(8'h60, 3, 0, 8'h60, 1'b0);
        bytes(nfc_pkg::KIND_ADDR, 3);
        step(KC, 1'b0, 8'h33);
        op(8'h00, 0, 0, 8'h05, 1'b0);
        bytes(nfc_pkg::KIND_ADDR, 2);
        step(KC, 1'b0, 8'hE0);
        step(KC, 1'b0, 8'hFF);
        step(KC, 1'b1, 8'hE0);
        repeat (100) @(negedge clock_in);
        check("drained", 8'(exp_q.size()), 8'h00);
        check("write protect", {7'h0, wp_n_out}, 8'h01);
        give_verdict;
    end
endmodule
`default_nettype wire

// *** verilog/nfc_host.sv ***
// nfc_host: host-side controller driving a multiplexed 8-bit flash device
// assumes one 50 MHz clock; pins cross in through two flip-flops, the
// board resolves the shared i/o wires from io_oe_out
`timescale 1ns/1ns
`default_nettype none

module nfc_host #(
    parameter int STROBE_CYC_P = nfc_pkg::STROBE_CYC,
    parameter int HOLD_CYC_P   = nfc_pkg::HOLD_CYC,
    parameter int RD_LOW_CYC_P = nfc_pkg::RD_LOW_CYC,
    parameter int WB_CYC_P     = nfc_pkg::WB_CYC
) (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    // request port
    input  wire logic       req_valid_in,
    output logic            req_ready_out,
    input  wire logic [1:0] req_kind_in,
    input  wire logic [7:0] req_byte_in,
    output logic            req_err_out,
    // read data port
    output logic            rd_valid_out,
    input  wire logic       rd_ready_in,
    output logic [7:0]      rd_data_out,
    // status
    output logic            busy_out,
    // flash pins
    output logic            ce_n_out,
    output logic            cle_out,
    output logic            ale_out,
    output logic            we_n_out,
    output logic            read_strobe_n_out,
    output logic            wp_n_out,
    input  wire logic [7:0] io_in,
    output logic [7:0]      io_out,
    output logic            io_oe_out,
    input  wire logic       ready_busy_in
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (STROBE_CYC_P < 1 || HOLD_CYC_P < 1 || WB_CYC_P < 1 ||
        RD_LOW_CYC_P < nfc_pkg::SYNC_STAGES + 1 || RD_LOW_CYC_P > 15 ||
        STROBE_CYC_P > 15 || HOLD_CYC_P > 15 || WB_CYC_P > 15) begin : g_chk
        $error("nfc_host: timing parameter out of range");
    end

    localparam logic [3:0] STROBE_C = 4'(STROBE_CYC_P - 1);
    localparam logic [3:0] HOLD_C   = 4'(HOLD_CYC_P - 1);
    localparam logic [3:0] RDLOW_C  = 4'(RD_LOW_CYC_P - 1);
    localparam logic [3:0] WB_C     = 4'(WB_CYC_P - 1);

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers
    function automatic logic cmd_known(input logic [7:0] b);
        case (b)
            nfc_pkg::C_READ, nfc_pkg::C_RND_OUT, nfc_pkg::C_PROG_GO,
            nfc_pkg::C_PLANE_BRK, nfc_pkg::C_CACHE_GO, nfc_pkg::C_READ_GO,
            nfc_pkg::C_CACHE_RD, nfc_pkg::C_TP_CACHE, nfc_pkg::C_CB_GO,
            nfc_pkg::C_ICB_GO, nfc_pkg::C_LAST_RD, nfc_pkg::C_ERASE,
            nfc_pkg::C_STATUS, nfc_pkg::C_PROG, nfc_pkg::C_PROG2,
            nfc_pkg::C_CB_PROG, nfc_pkg::C_ICB_PROG, nfc_pkg::C_READ_ID,
            nfc_pkg::C_ERASE_GO, nfc_pkg::C_RND_GO, nfc_pkg::C_PARAM,
            nfc_pkg::C_SET_FEAT, nfc_pkg::C_STAT_C0, nfc_pkg::C_STAT_C1,
            nfc_pkg::C_RESET: cmd_known = 1'b1;
            default:          cmd_known = 1'b0;
        endcase
    endfunction

    // execution codes that close a setup
    function automatic logic is_confirm(input logic [7:0] b);
        case (b)
            nfc_pkg::C_READ_GO, nfc_pkg::C_CB_GO, nfc_pkg::C_ICB_GO,
            nfc_pkg::C_TP_CACHE, nfc_pkg::C_PROG_GO, nfc_pkg::C_CACHE_GO,
            nfc_pkg::C_PLANE_BRK, nfc_pkg::C_ERASE_GO: is_confirm = 1'b1;
            default:                                   is_confirm = 1'b0;
        endcase
    endfunction

    // codes after which the device goes busy
    function automatic logic starts_busy(input logic [7:0] b);
        starts_busy = is_confirm(b) || b == nfc_pkg::C_CACHE_RD ||
                      b == nfc_pkg::C_LAST_RD || b == nfc_pkg::C_RESET;
    endfunction

    // status reads and reset
    function automatic logic is_status(input logic [7:0] b);
        is_status = b == nfc_pkg::C_STATUS || b == nfc_pkg::C_STAT_C0 ||
                    b == nfc_pkg::C_STAT_C1 || b == nfc_pkg::C_RESET;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // whole state
    typedef struct packed {
        nfc_pkg::nfc_state_e st;
        nfc_pkg::nfc_phase_e phase;
        logic [3:0]          cnt;
        logic [1:0]          kind;
        logic                busy_pend;
        logic [2:0]          addr_cnt;
        logic                tp_setup;   // second 60h seen
        logic                tp_read;    // last read was two-plane
        logic                page_open;
        logic                plane_brk;
        logic                ce_n;
        logic                cle;
        logic                ale;
        logic                we_n;
        logic                re_n;
        logic                io_oe;
        logic [7:0]          io_dat;
        logic                err;
        logic [1:0][7:0]     mem;
        logic                wp;
        logic                rp;
        logic [1:0]          fill;
        logic [7:0]          io_s1;
        logic [7:0]          io_s2;
        logic                rb_s1;
        logic                rb_s2;
    } nfc_state_s;

    nfc_state_s s_r;
    nfc_state_s s_nxt;
    logic       take;
    logic       push;
    logic       pop;
    logic       ok;
    logic [2:0] need;

    ////////////////////////////////////////////////////////////////////////
    // handshake outputs
    assign req_ready_out = s_r.st == nfc_pkg::ST_IDLE &&
                           (req_kind_in != nfc_pkg::KIND_RDATA ||
                            s_r.fill != 2'h2);
    assign take          = req_valid_in && req_ready_out;
    assign pop           = rd_valid_out && rd_ready_in;
    assign rd_valid_out  = s_r.fill != 2'h0;
    assign rd_data_out   = s_r.mem[s_r.rp];

    // registered pin and status outputs; write protect tied high
    assign req_err_out       = s_r.err;
    assign busy_out          = s_r.st == nfc_pkg::ST_BUSY;
    assign ce_n_out          = s_r.ce_n;
    assign cle_out           = s_r.cle;
    assign ale_out           = s_r.ale;
    assign we_n_out          = s_r.we_n;
    assign read_strobe_n_out = s_r.re_n;
    assign wp_n_out          = 1'b1;
    assign io_out            = s_r.io_dat;
    assign io_oe_out         = s_r.io_oe;

    // address bytes a confirm expects
    always_comb begin
        case (s_r.phase)
            nfc_pkg::PH_READ,
            nfc_pkg::PH_PROG:  need = nfc_pkg::ADDR_FULL;
            nfc_pkg::PH_ERASE: need = nfc_pkg::ADDR_ROW;
            default:           need = 3'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt       = s_r;
        s_nxt.err   = 1'b0;
        push        = 1'b0;
        ok          = 1'b1;
        // pin synchronisers
        s_nxt.io_s1 = io_in;
        s_nxt.io_s2 = s_r.io_s1;
        s_nxt.rb_s1 = ready_busy_in;
        s_nxt.rb_s2 = s_r.rb_s1;
        case (s_r.st)
            nfc_pkg::ST_IDLE: begin
                if (take) begin
                    if (req_kind_in == nfc_pkg::KIND_CMD) begin
                        if (!cmd_known(req_byte_in))
                            ok = 1'b0;
                        else if (s_r.plane_brk && !is_status(req_byte_in) &&
                                 req_byte_in != nfc_pkg::C_PROG &&
                                 req_byte_in != nfc_pkg::C_PROG2 &&
                                 req_byte_in != nfc_pkg::C_CB_PROG)
                            ok = 1'b0;
                        else if (is_confirm(req_byte_in) &&
                                 (need == 3'h0 || s_r.addr_cnt != need))
                            ok = 1'b0;
                        else if (req_byte_in == nfc_pkg::C_RND_OUT &&
                                 (!s_r.page_open ||
                                  (s_r.phase == nfc_pkg::PH_READ &&
                                   !s_r.tp_read)))
                            ok = 1'b0;
                        else if (req_byte_in == nfc_pkg::C_RND_GO &&
                                 !s_r.page_open)
                            ok = 1'b0;
                    end
                    if (!ok) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.kind   = req_kind_in;
                        s_nxt.io_dat = req_byte_in;
                        s_nxt.ce_n   = 1'b0;
                        s_nxt.cle    = req_kind_in == nfc_pkg::KIND_CMD;
                        s_nxt.ale    = req_kind_in == nfc_pkg::KIND_ADDR;
                        s_nxt.io_oe  = req_kind_in != nfc_pkg::KIND_RDATA;
                        s_nxt.we_n   = req_kind_in == nfc_pkg::KIND_RDATA;
                        s_nxt.re_n   = req_kind_in != nfc_pkg::KIND_RDATA;
                        s_nxt.cnt    = req_kind_in == nfc_pkg::KIND_RDATA ?
                                       RDLOW_C : STROBE_C;
                        s_nxt.st     = nfc_pkg::ST_LOW;
                        s_nxt.busy_pend = 1'b0;
                        if (req_kind_in == nfc_pkg::KIND_ADDR &&
                            s_r.addr_cnt != 3'h7)
                            s_nxt.addr_cnt = s_r.addr_cnt + 3'h1;
                        if (req_kind_in == nfc_pkg::KIND_CMD) begin
                            s_nxt.busy_pend = starts_busy(req_byte_in);
                            s_nxt.addr_cnt  = 3'h0;
                            // a stray code drops the pending setup
                            s_nxt.phase     = nfc_pkg::PH_NONE;
                            s_nxt.tp_setup  = 1'b0;
                            if (is_status(req_byte_in) &&
                                req_byte_in != nfc_pkg::C_RESET) begin
                                s_nxt.phase    = s_r.phase;
                                s_nxt.addr_cnt = s_r.addr_cnt;
                                s_nxt.tp_setup = s_r.tp_setup;
                            end
                            case (req_byte_in)
                                nfc_pkg::C_READ:
                                    s_nxt.phase = nfc_pkg::PH_READ;
                                nfc_pkg::C_PROG, nfc_pkg::C_PROG2,
                                nfc_pkg::C_CB_PROG,
                                nfc_pkg::C_ICB_PROG: begin
                                    s_nxt.phase     = nfc_pkg::PH_PROG;
                                    s_nxt.plane_brk = 1'b0;
                                end
                                nfc_pkg::C_ERASE: begin
                                    s_nxt.phase    = nfc_pkg::PH_ERASE;
                                    s_nxt.tp_setup =
                                        s_r.phase == nfc_pkg::PH_ERASE &&
                                        s_r.addr_cnt == nfc_pkg::ADDR_ROW;
                                end
                                nfc_pkg::C_READ_GO, nfc_pkg::C_TP_CACHE: begin
                                    s_nxt.tp_read   = s_r.tp_setup;
                                    s_nxt.page_open = 1'b1;
                                end
                                nfc_pkg::C_CB_GO, nfc_pkg::C_ICB_GO: begin
                                    s_nxt.tp_read   = 1'b0;
                                    s_nxt.page_open = 1'b1;
                                end
                                nfc_pkg::C_PLANE_BRK:
                                    s_nxt.plane_brk = 1'b1;
                                nfc_pkg::C_PROG_GO, nfc_pkg::C_CACHE_GO,
                                nfc_pkg::C_ERASE_GO, nfc_pkg::C_RESET: begin
                                    s_nxt.page_open = 1'b0;
                                    s_nxt.tp_read   = 1'b0;
                                    s_nxt.plane_brk = 1'b0;
                                end
                                default: ;
                            endcase
                        end
                    end
                end else begin
                    s_nxt.ce_n = 1'b1;
                end
            end
            nfc_pkg::ST_LOW: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    // rising strobe edge latches or ends the read
                    s_nxt.we_n = 1'b1;
                    s_nxt.re_n = 1'b1;
                    s_nxt.cnt  = HOLD_C;
                    s_nxt.st   = nfc_pkg::ST_HIGH;
                    if (s_r.kind == nfc_pkg::KIND_RDATA) begin
                        push            = 1'b1;
                        s_nxt.mem[s_r.wp] = s_r.io_s2;
                        s_nxt.wp        = ~s_r.wp;
                    end
                end
            end
            nfc_pkg::ST_HIGH: begin
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    s_nxt.cle   = 1'b0;
                    s_nxt.ale   = 1'b0;
                    s_nxt.io_oe = 1'b0;
                    s_nxt.cnt   = WB_C;
                    s_nxt.st    = s_r.busy_pend ? nfc_pkg::ST_BUSY
                                                : nfc_pkg::ST_IDLE;
                end
            end
            nfc_pkg::ST_BUSY: begin
                // let busy assert, then wait for ready
                if (s_r.cnt != 4'h0)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else if (s_r.rb_s2)
                    s_nxt.st = nfc_pkg::ST_IDLE;
            end
            default: s_nxt.st = nfc_pkg::ST_IDLE;
        endcase
        // buffer pop pointer and fill
        if (pop)
            s_nxt.rp = ~s_r.rp;
        s_nxt.fill = s_r.fill + {1'b0, push} - {1'b0, pop};
    end

    ////////////////////////////////////////////////////////////////////////
    // register
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            s_r          <= '0;
            s_r.st       <= nfc_pkg::ST_IDLE;
            s_r.phase    <= nfc_pkg::PH_NONE;
            s_r.ce_n     <= 1'b1;
            s_r.we_n     <= 1'b1;
            s_r.re_n     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

// *** verilog/nfc_pkg.sv ***
// nfc_pkg: constants, codes and state types of the flash host controller
// assumes a 50 MHz system clock; all times below are in nanoseconds
package nfc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and pin timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_STROBE_NS   = 25;   // least write/read strobe low
    localparam int T_HOLD_NS     = 25;   // least strobe high and hold
    localparam int T_REA_NS      = 20;   // data valid after read strobe fall
    localparam int T_WB_NS       = 100;  // confirm to busy going low
    localparam int SYNC_STAGES   = 2;

    // least times round up to whole cycles
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int REA_CYC    = (T_REA_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int RD_LOW_CYC = REA_CYC + SYNC_STAGES;
    localparam int WB_CYC     = (T_WB_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // address cycle counts
    localparam logic [2:0] ADDR_FULL = 3'h5;   // column then row
    localparam logic [2:0] ADDR_ROW  = 3'h3;   // row only

    // request kinds
    localparam logic [1:0] KIND_CMD   = 2'h0;
    localparam logic [1:0] KIND_ADDR  = 2'h1;
    localparam logic [1:0] KIND_WDATA = 2'h2;
    localparam logic [1:0] KIND_RDATA = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0] C_READ     = 8'h00;
    localparam logic [7:0] C_RND_OUT  = 8'h05;
    localparam logic [7:0] C_PROG_GO  = 8'h10;
    localparam logic [7:0] C_PLANE_BRK= 8'h11;
    localparam logic [7:0] C_CACHE_GO = 8'h15;
    localparam logic [7:0] C_READ_GO  = 8'h30;
    localparam logic [7:0] C_CACHE_RD = 8'h31;
    localparam logic [7:0] C_TP_CACHE = 8'h33;
    localparam logic [7:0] C_CB_GO    = 8'h35;
    localparam logic [7:0] C_ICB_GO   = 8'h3A;
    localparam logic [7:0] C_LAST_RD  = 8'h3F;
    localparam logic [7:0] C_ERASE    = 8'h60;
    localparam logic [7:0] C_STATUS   = 8'h70;
    localparam logic [7:0] C_PROG     = 8'h80;
    localparam logic [7:0] C_PROG2    = 8'h81;
    localparam logic [7:0] C_CB_PROG  = 8'h85;
    localparam logic [7:0] C_ICB_PROG = 8'h8C;
    localparam logic [7:0] C_READ_ID  = 8'h90;
    localparam logic [7:0] C_ERASE_GO = 8'hD0;
    localparam logic [7:0] C_RND_GO   = 8'hE0;
    localparam logic [7:0] C_PARAM    = 8'hEC;
    localparam logic [7:0] C_SET_FEAT = 8'hEF;
    localparam logic [7:0] C_STAT_C0  = 8'hF1;
    localparam logic [7:0] C_STAT_C1  = 8'hF2;
    localparam logic [7:0] C_RESET    = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOW   = 2'b01,
        ST_HIGH  = 2'b10,
        ST_BUSY  = 2'b11
    } nfc_state_e;

    typedef enum logic [1:0] {
        PH_NONE  = 2'b00,
        PH_READ  = 2'b01,
        PH_PROG  = 2'b10,
        PH_ERASE = 2'b11
    } nfc_phase_e;

endpackage
